// file: spid_pkg.sv
package spid_pkg;
    localparam int INSTR_BITS = 16;
    localparam int ADDR_BITS = 13;
    localparam logic [12:0] TOP_ADDR = 13'h0232;
    localparam logic [12:0] CFG_ADDR = 13'h0000;
    localparam logic [12:0] PART_ID_ADDR = 13'h0003;
    localparam logic [12:0] RB_CTL_ADDR = 13'h0004;
    localparam logic [7:0] CFG_RESET = 8'h18;
    localparam int CFG_SDO_BIT = 0;
    localparam int CFG_LSB_LO = 1;
    localparam int CFG_LSB_HI = 6;
    localparam int UPDATE_BIT = 0;
    localparam int RB_ACTIVE_BIT = 0;
    localparam logic [1:0] LEN_STREAM = 2'h3;
    // controller command registers, byte addresses
    localparam logic [4:0] REG_CTRL = 5'h00;
    localparam logic [4:0] REG_ADDR = 5'h04;
    localparam logic [4:0] REG_TX = 5'h08;
    localparam logic [4:0] REG_RX = 5'h0C;
    localparam logic [4:0] REG_STAT = 5'h10;
    localparam int CTRL_START = 0;
    localparam int CTRL_RNW = 1;
    localparam int CTRL_LEN_LO = 2;
    localparam int CTRL_LSB = 4;
    localparam int CTRL_SDO = 5;
    localparam int CTRL_CNT_LO = 8;
    localparam int STAT_BUSY = 0;
    localparam int STAT_DONE = 1;
    localparam int HOST_HALF_DIV = 4;

    typedef enum logic [2:0] {
        ST_INSTR = 3'b001,
        ST_DATA = 3'b010,
        ST_DONE = 3'b100
    } spid_dstate_t;

    typedef enum logic [2:0] {
        H_IDLE = 3'b001,
        H_SHIFT = 3'b010,
        H_END = 3'b100
    } spid_hstate_t;

    // position of bit b of a byte in transmission order
    function automatic logic [2:0] bitSel(input logic lsb,
        input logic [2:0] b);
        return lsb ? b : ~b;
    endfunction : bitSel
endpackage : spid_pkg

// file: spid_if.sv
`timescale 1ns/10ps
`default_nettype none
interface spid_if;
    logic csN;
    logic sclk;
    logic hostSdio;
    logic hostSdioOe;
    logic devSdio;
    logic devSdioOe;
    logic devSdo;
    logic devSdoOe;
    logic sdioLevel;
    logic sdoLevel;

    // undriven lines read low
    assign sdioLevel = devSdioOe ? devSdio : (hostSdioOe ? hostSdio : 1'b0);
    assign sdoLevel = devSdoOe ? devSdo : 1'b0;

    modport device (
        input csN, sclk, sdioLevel,
        output devSdio, devSdioOe, devSdo, devSdoOe
    );
    modport host (
        output csN, sclk, hostSdio, hostSdioOe,
        input sdioLevel, sdoLevel
    );
endinterface : spid_if
`default_nettype wire

// file: spid_sync.sv
`timescale 1ns/10ps
`default_nettype none
module spid_sync #(
    parameter int WIDTH = 1
) (
    input wire logic clk, // sampling clock
    input wire logic resetn, // sync reset, active low
    input wire logic [WIDTH-1:0] asyncIn, // pin levels
    output logic [WIDTH-1:0] syncOut // synchronised levels
);
    logic [WIDTH-1:0] meta_ff;
    logic [WIDTH-1:0] sync_ff;

    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            meta_ff <= '0;
            sync_ff <= '0;
        end
        else
        begin
            meta_ff <= asyncIn;
            sync_ff <= meta_ff;
        end
    end

    assign syncOut = sync_ff;
endmodule : spid_sync
`default_nettype wire

// file: spid_device.sv
`timescale 1ns/10ps
`default_nettype none
// Overview of operation
// RULE_01: 16-bit instruction: rw, length, 13-bit address
// RULE_02: length 00/01/10 gives 1-3 bytes, 11 streams
// RULE_03: host sends upper three address bits zero
// RULE_04: MSB-first decrements address after each byte
// RULE_05: LSB-first increments address after each byte
// RULE_06: host mirrors nibbles written to config register; host mirrors only when the write starts there
// RULE_07: MSB-first default, LSB-first bits act immediately
// RULE_08: config resets to 0x18, long instruction
// RULE_09: bit order per byte follows configured order
// RULE_10: host starts at address of first-sent byte
// RULE_11: streaming stops after top address is handled
// RULE_12: sequencer steps every address, never skipping
// RULE_13: cs low starts; sample rising, launch falling
// RULE_14: writes buffered, copied on self-clearing update bit
// RULE_15: readback on shared pin, or separate pin
// RULE_16: cs rise off byte boundary aborts and flushes
// RULE_17: bit counter restarts at zero per transfer
module spid_device #(
    parameter logic [7:0] PART_ID = 8'h5A // arbitrary value
) (
    spid_if.device link, // serial port pins
    input wire logic resetn, // sync reset on sclk, active low
    input wire logic [9:0] userAddr, // active register index
    output logic [7:0] userData, // active register contents
    output logic lsbFirst, // current bit order
    output logic sdoActive, // readback on separate pin
    output logic updatePulse // active registers reloaded
);
    localparam int DEPTH = int'(spid_pkg::TOP_ADDR) + 1;

    spid_pkg::spid_dstate_t state_ff;
    logic [7:0] buffer_ff [DEPTH];
    logic [7:0] active_ff [DEPTH];
    logic [7:0] cfg_ff;
    logic [15:0] instr_ff;
    logic [7:0] byte_ff;
    logic [3:0] bitCnt_ff;
    logic rnw_ff;
    logic stream_ff;
    logic [1:0] remain_ff;
    logic [12:0] addr_ff;
    logic [7:0] rdByte_ff;
    logic rdBit_ff;
    logic rdOe_ff;
    logic [7:0] userData_ff;
    logic update_ff;

    wire logic din = link.sdioLevel;
    wire logic csHigh = link.csN;
    // both mirrored copies honoured so a half-written setting still acts
    wire logic lsb = cfg_ff[spid_pkg::CFG_LSB_LO] |
        cfg_ff[spid_pkg::CFG_LSB_HI]; // [RULE_07]
    wire logic inInstr = (state_ff == spid_pkg::ST_INSTR);
    wire logic inData = (state_ff == spid_pkg::ST_DATA);
    wire logic [3:0] instrPos = lsb ? bitCnt_ff : ~bitCnt_ff; // [RULE_09]
    wire logic [2:0] dataPos = spid_pkg::bitSel(lsb, bitCnt_ff[2:0]);
    wire logic [15:0] instrNow = instr_ff |
        (16'(din) << instrPos); // [RULE_09]
    wire logic [7:0] byteNow = byte_ff | (8'(din) << dataPos); // [RULE_09]
    wire logic instrDone = inInstr && (bitCnt_ff == 4'hF); // [RULE_01]
    wire logic byteDone = inData && (bitCnt_ff[2:0] == 3'h7);
    wire logic boundary = (bitCnt_ff[2:0] == 3'h0);
    wire logic [1:0] lenNow = instrNow[14:13]; // [RULE_01]

    // every address is visited, reserved and blank ones included
    wire logic [12:0] stepAddr = lsb ? 13'(addr_ff + 13'h0001) :
        (addr_ff == spid_pkg::CFG_ADDR) ? spid_pkg::TOP_ADDR :
        13'(addr_ff - 13'h0001); // [RULE_04] [RULE_05] [RULE_11] [RULE_12]
    wire logic lastByte = stream_ff ? (addr_ff == spid_pkg::TOP_ADDR) :
        (remain_ff == 2'h1); // [RULE_02] [RULE_11]

    wire logic [12:0] rdAddr = instrDone ? instrNow[12:0] : stepAddr;
    wire logic rdInMap = (rdAddr <= spid_pkg::TOP_ADDR);
    wire logic rbActive =
        buffer_ff[spid_pkg::RB_CTL_ADDR[9:0]][spid_pkg::RB_ACTIVE_BIT];
    wire logic [7:0] rdValue =
        (rdAddr == spid_pkg::CFG_ADDR) ? cfg_ff :
        (rdAddr == spid_pkg::PART_ID_ADDR) ? PART_ID :
        !rdInMap ? 8'h00 :
        rbActive ? active_ff[rdAddr[9:0]] : buffer_ff[rdAddr[9:0]];

    wire logic wrHit = byteDone && !rnw_ff && !csHigh;
    wire logic wrCfg = wrHit && (addr_ff == spid_pkg::CFG_ADDR);
    wire logic wrBuf = wrHit && (addr_ff <= spid_pkg::TOP_ADDR) &&
        (addr_ff != spid_pkg::CFG_ADDR) &&
        (addr_ff != spid_pkg::PART_ID_ADDR);
    wire logic wrTop = wrHit && (addr_ff == spid_pkg::TOP_ADDR);
    wire logic doUpdate = wrTop && byteNow[spid_pkg::UPDATE_BIT];
    // stall only on a byte boundary: after eight instruction bits, or in the data of a bounded transfer
    wire logic stallOk = boundary && ((inInstr && bitCnt_ff[3]) ||
        (inData && !stream_ff));

    // sequencer and shifter, all on rising sclk
    always_ff @(posedge link.sclk)
    begin
        if (!resetn)
        begin
            state_ff <= spid_pkg::ST_INSTR;
            bitCnt_ff <= 4'h0;
            instr_ff <= 16'h0000;
            byte_ff <= 8'h00;
            rnw_ff <= 1'b0;
            stream_ff <= 1'b0;
            remain_ff <= 2'h0;
            addr_ff <= 13'h0000;
            rdByte_ff <= 8'h00;
        end
        else if (csHigh)
        begin
            byte_ff <= 8'h00; // [RULE_16]
            if (!stallOk)
            begin
                state_ff <= spid_pkg::ST_INSTR; // [RULE_16]
                bitCnt_ff <= 4'h0; // [RULE_17]
                instr_ff <= 16'h0000; // [RULE_17]
            end
        end
        else
        begin
            unique case (state_ff)
                spid_pkg::ST_INSTR:
                begin
                    if (instrDone)
                    begin
                        rnw_ff <= instrNow[15]; // [RULE_01]
                        stream_ff <= (lenNow == spid_pkg::LEN_STREAM);
                        remain_ff <= 2'(lenNow + 2'h1); // [RULE_02]
                        addr_ff <= instrNow[12:0]; // [RULE_01]
                        rdByte_ff <= rdValue;
                        instr_ff <= 16'h0000;
                        bitCnt_ff <= 4'h0;
                        state_ff <= spid_pkg::ST_DATA;
                    end
                    else
                    begin
                        instr_ff <= instrNow; // [RULE_13]
                        bitCnt_ff <= 4'(bitCnt_ff + 4'h1);
                    end
                end
                spid_pkg::ST_DATA:
                begin
                    if (byteDone)
                    begin
                        byte_ff <= 8'h00;
                        bitCnt_ff <= 4'h0;
                        addr_ff <= stepAddr; // [RULE_04] [RULE_05]
                        remain_ff <= 2'(remain_ff - 2'h1);
                        rdByte_ff <= rdValue;
                        if (lastByte)
                        begin
                            state_ff <= spid_pkg::ST_DONE; // [RULE_11]
                        end
                    end
                    else
                    begin
                        byte_ff <= rnw_ff ? 8'h00 : byteNow; // [RULE_13]
                        bitCnt_ff <= 4'(bitCnt_ff + 4'h1);
                    end
                end
                spid_pkg::ST_DONE:
                begin
                    bitCnt_ff <= 4'h0;
                end
            endcase
        end
    end

    // buffered registers; cfg and the RB_CTL_ADDR readback select act at once, the rest after an update
    always_ff @(posedge link.sclk)
    begin
        if (!resetn)
        begin
            cfg_ff <= spid_pkg::CFG_RESET; // [RULE_08]
            buffer_ff <= '{default: 8'h00};
            active_ff <= '{default: 8'h00};
            update_ff <= 1'b0;
            userData_ff <= 8'h00;
        end
        else
        begin
            if (wrCfg)
            begin
                cfg_ff <= byteNow; // [RULE_07]
            end
            if (wrBuf)
            begin
                buffer_ff[addr_ff[9:0]] <= wrTop ?
                    (byteNow & ~8'h01) : byteNow; // [RULE_14]
            end
            if (doUpdate)
            begin
                active_ff <= buffer_ff; // [RULE_14]
            end
            update_ff <= doUpdate;
            userData_ff <= (userAddr <= spid_pkg::TOP_ADDR[9:0]) ?
                active_ff[userAddr] : 8'h00;
        end
    end

    // readback launched on falling sclk so it is stable at the next rise
    always_ff @(negedge link.sclk)
    begin
        if (!resetn)
        begin
            rdBit_ff <= 1'b0;
            rdOe_ff <= 1'b0;
        end
        else
        begin
            rdBit_ff <= rdByte_ff[dataPos]; // [RULE_13] [RULE_09]
            rdOe_ff <= inData && rnw_ff && !csHigh;
        end
    end

    wire logic sdoSel = cfg_ff[spid_pkg::CFG_SDO_BIT];
    assign link.devSdio = rdBit_ff;
    assign link.devSdo = rdBit_ff;
    assign link.devSdioOe = rdOe_ff && !csHigh && !sdoSel; // [RULE_15]
    assign link.devSdoOe = rdOe_ff && !csHigh && sdoSel; // [RULE_15]
    assign userData = userData_ff;
    assign lsbFirst = lsb;
    assign sdoActive = sdoSel;
    assign updatePulse = update_ff;
endmodule : spid_device
`default_nettype wire

// file: spid_host.sv
// Our own choice: register access over Avalon-MM.
`timescale 1ns/10ps
`default_nettype none
module spid_host #(
    parameter int HALF_DIV = spid_pkg::HOST_HALF_DIV // mclk per sclk half
) (
    input wire logic mclk, // controller clock
    input wire logic resetn, // sync reset, active low
    input wire logic [4:0] avAddress, // byte address
    input wire logic avRead, // read request
    input wire logic avWrite, // write request
    input wire logic [31:0] avWriteData, // write data
    output logic [31:0] avReadData, // read data
    output logic avWaitrequest, // slave not ready
    spid_if.host link // serial port pins
);
    spid_pkg::spid_hstate_t state_ff;
    logic ack_ff;
    logic [31:0] rdData_ff;
    logic [10:0] ctrl_ff;
    logic [12:0] addr_ff;
    logic [31:0] tx_ff;
    logic [31:0] rx_ff;
    logic busy_ff;
    logic done_ff;
    logic pending_ff;
    logic [7:0] divCnt_ff;
    logic sclk_ff;
    logic csN_ff;
    logic mosi_ff;
    logic oe_ff;
    logic [5:0] bitIdx_ff;
    logic [1:0] pinSync;

    spid_sync #(.WIDTH(2)) pinSyncInst (
        .clk(mclk),
        .resetn(resetn),
        .asyncIn({link.sdoLevel, link.sdioLevel}),
        .syncOut(pinSync)
    );

    wire logic rnw = ctrl_ff[spid_pkg::CTRL_RNW];
    wire logic [1:0] len = ctrl_ff[spid_pkg::CTRL_LEN_LO +: 2];
    wire logic lsb = ctrl_ff[spid_pkg::CTRL_LSB];
    wire logic [2:0] cnt = ctrl_ff[spid_pkg::CTRL_CNT_LO +: 3];
    wire logic [2:0] nBytes = (len != spid_pkg::LEN_STREAM) ?
        3'(len + 2'h1) : ((cnt == 3'h0) ? 3'h1 :
        (cnt > 3'h4) ? 3'h4 : cnt);
    wire logic [5:0] lastIdx = 6'(6'h0F + {nBytes, 3'b000});
    wire logic rxPin = ctrl_ff[spid_pkg::CTRL_SDO] ? pinSync[1] : pinSync[0];
    // software's start address is sent as the first byte's address
    wire logic [15:0] instrWord = {rnw, len, 3'b000,
        addr_ff[9:0]}; // [RULE_03] [RULE_10]
    wire logic inInstr = (bitIdx_ff < 6'h10);
    wire logic [5:0] dk = 6'(bitIdx_ff - 6'h10);
    wire logic [2:0] bitPos = spid_pkg::bitSel(lsb, dk[2:0]);
    wire logic [7:0] txRaw = tx_ff[{dk[4:3], 3'b000} +: 8];
    wire logic mirror = !rnw && (addr_ff == spid_pkg::CFG_ADDR) &&
        (dk[4:3] == 2'h0);
    wire logic [7:0] txByte = mirror ? {txRaw[0], txRaw[1], txRaw[2],
        txRaw[3], txRaw[3:0]} : txRaw; // [RULE_06]
    wire logic txBit = inInstr ?
        instrWord[lsb ? bitIdx_ff[3:0] : ~bitIdx_ff[3:0]] : txByte[bitPos];
    wire logic tick = (divCnt_ff == 8'(HALF_DIV - 1));
    wire logic riseEv = tick && !sclk_ff;
    wire logic fallEv = tick && sclk_ff;
    wire logic wrEn = avWrite && ack_ff;
    wire logic startReq = wrEn && (avAddress == spid_pkg::REG_CTRL) &&
        avWriteData[spid_pkg::CTRL_START] && !busy_ff;
    wire logic [31:0] rdMux =
        (avAddress == spid_pkg::REG_CTRL) ? {21'h0, ctrl_ff} :
        (avAddress == spid_pkg::REG_ADDR) ? {19'h0, addr_ff} :
        (avAddress == spid_pkg::REG_TX) ? tx_ff :
        (avAddress == spid_pkg::REG_RX) ? rx_ff :
        (avAddress == spid_pkg::REG_STAT) ? {30'h0, done_ff, busy_ff} :
        32'h0000_0000;

    assign avWaitrequest = (avRead || avWrite) && !ack_ff;

    always_ff @(posedge mclk)
    begin
        if (!resetn)
        begin
            ack_ff <= 1'b0;
            rdData_ff <= 32'h0000_0000;
            ctrl_ff <= 11'h000;
            addr_ff <= 13'h0000;
            tx_ff <= 32'h0000_0000;
        end
        else
        begin
            ack_ff <= (avRead || avWrite) && !ack_ff;
            if (avRead && !ack_ff)
            begin
                rdData_ff <= rdMux;
            end
            if (wrEn && !busy_ff)
            begin
                if (avAddress == spid_pkg::REG_CTRL)
                begin
                    ctrl_ff <= {avWriteData[10:1], 1'b0};
                end
                if (avAddress == spid_pkg::REG_ADDR)
                begin
                    addr_ff <= avWriteData[12:0];
                end
                if (avAddress == spid_pkg::REG_TX)
                begin
                    tx_ff <= avWriteData;
                end
            end
        end
    end

    // free-running divider; sclk rests low in reset, so the far end
    // must hold its own reset over a few sclk rises after release
    always_ff @(posedge mclk)
    begin
        if (!resetn)
        begin
            divCnt_ff <= 8'h00;
            sclk_ff <= 1'b0;
        end
        else
        begin
            divCnt_ff <= tick ? 8'h00 : 8'(divCnt_ff + 8'h01);
            sclk_ff <= tick ? !sclk_ff : sclk_ff;
        end
    end

    always_ff @(posedge mclk)
    begin
        if (!resetn)
        begin
            state_ff <= spid_pkg::H_IDLE;
            busy_ff <= 1'b0;
            done_ff <= 1'b0;
            pending_ff <= 1'b0;
            csN_ff <= 1'b1;
            mosi_ff <= 1'b0;
            oe_ff <= 1'b0;
            bitIdx_ff <= 6'h00;
            rx_ff <= 32'h0000_0000;
        end
        else
        begin
            unique case (state_ff)
                spid_pkg::H_IDLE:
                begin
                    if (startReq)
                    begin
                        busy_ff <= 1'b1;
                        done_ff <= 1'b0;
                        pending_ff <= 1'b1;
                        rx_ff <= 32'h0000_0000;
                        bitIdx_ff <= 6'h00;
                    end
                    else if (pending_ff && fallEv)
                    begin
                        pending_ff <= 1'b0;
                        csN_ff <= 1'b0;
                        mosi_ff <= txBit;
                        oe_ff <= 1'b1;
                        state_ff <= spid_pkg::H_SHIFT;
                    end
                end
                spid_pkg::H_SHIFT:
                begin
                    if (riseEv)
                    begin
                        if (rnw && !inInstr)
                        begin
                            rx_ff[{dk[4:3], bitPos}] <= rxPin;
                        end
                        bitIdx_ff <= 6'(bitIdx_ff + 6'h01);
                        if (bitIdx_ff == lastIdx)
                        begin
                            state_ff <= spid_pkg::H_END;
                        end
                    end
                    else if (fallEv)
                    begin
                        mosi_ff <= txBit;
                        oe_ff <= inInstr || !rnw;
                    end
                end
                spid_pkg::H_END:
                begin
                    if (fallEv)
                    begin
                        csN_ff <= 1'b1;
                        oe_ff <= 1'b0;
                        busy_ff <= 1'b0;
                        done_ff <= 1'b1;
                        state_ff <= spid_pkg::H_IDLE;
                    end
                end
            endcase
        end
    end

    assign avReadData = rdData_ff;
    assign link.csN = csN_ff;
    assign link.sclk = sclk_ff;
    assign link.hostSdio = mosi_ff;
    assign link.hostSdioOe = oe_ff;
endmodule : spid_host
`default_nettype wire

// file: spid_props.sv
`timescale 1ns/10ps
`default_nettype none
module spid_props (
    input wire logic sclk, // serial clock
    input wire logic resetn, // sync reset, active low
    input wire logic csN, // chip select, active low
    input wire logic hostSdioOe, // host drives data line
    input wire logic devSdioOe, // device drives data line
    input wire logic devSdoOe // device drives readback pin
);
    logic [15:0] bitCnt_ff;
    logic [15:0] nxt_bitCnt;
    logic devOe;

    // own count of rises in a frame, independent of either end
    assign devOe = devSdioOe | devSdoOe;
    assign nxt_bitCnt = csN ? 16'h0000 : bitCnt_ff + 16'h0001;
    always_ff @(posedge sclk)
    begin
        if (!resetn)
            bitCnt_ff <= 16'h0000;
        else
            bitCnt_ff <= nxt_bitCnt;
    end

    default clocking cb @(posedge sclk);
    endclocking
    default disable iff (!resetn);

    property p_onePin;
        !(devSdioOe && devSdoOe);
    endproperty
    a_onePin: assert property (p_onePin)
        else $error("both readback pins driven");
    property p_idleQuiet;
        csN |-> !devOe;
    endproperty
    a_idleQuiet: assert property (p_idleQuiet)
        else $error("device drives while deselected");
    property p_noClash;
        !(hostSdioOe && devSdioOe);
    endproperty
    a_noClash: assert property (p_noClash)
        else $error("both ends drive the data line");
    property p_hostInFrame;
        hostSdioOe |-> !csN;
    endproperty
    a_hostInFrame: assert property (p_hostInFrame)
        else $error("host drives outside a frame");
    property p_instrDriven;
        (!csN && bitCnt_ff < 16'h0010) |-> hostSdioOe;
    endproperty
    a_instrDriven: assert property (p_instrDriven)
        else $error("instruction bit not driven");
    property p_noEarlyRead;
        devOe |-> bitCnt_ff >= 16'h0010;
    endproperty
    a_noEarlyRead: assert property (p_noEarlyRead)
        else $error("readback before instruction ends");
    property p_firstRead;
        $rose(devOe) |-> bitCnt_ff == 16'h0010;
    endproperty
    a_firstRead: assert property (p_firstRead)
        else $error("readback not right after instruction");
    property p_endOnByte;
        $rose(csN) |-> bitCnt_ff >= 16'h0018 && bitCnt_ff[2:0] == 3'h0;
    endproperty
    a_endOnByte: assert property (p_endOnByte)
        else $error("frame ends off a byte boundary");
endmodule : spid_props
`default_nettype wire

// file: serial_port_instruction_decoder_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module serial_port_instruction_decoder_tb_top;
    typedef struct packed {
        logic [10:0] ctrl;
        logic [12:0] addr;
        logic [31:0] tx;
        logic [31:0] rx;
        logic [1:0] mode;
    } spid_row_t;
    // ctrl, start address, sent word, expected word, {sdo, lsb} after
    localparam spid_row_t ROWS [14] = '{
        '{11'h002, 13'h0000, 32'h0, 32'h00000018, 2'h0},
        '{11'h008, 13'h0012, 32'h00332211, 32'h0, 2'h0},
        '{11'h00A, 13'h0012, 32'h0, 32'h00332211, 2'h0},
        '{11'h006, 13'h0011, 32'h0, 32'h00003322, 2'h0},
        '{11'h000, 13'h0000, 32'h0000005A, 32'h0, 2'h1},
        '{11'h014, 13'h0020, 32'h0000BBAA, 32'h0, 2'h1},
        '{11'h01A, 13'h001F, 32'h0, 32'h00BBAA00, 2'h1},
        '{11'h016, 13'h0010, 32'h0, 32'h00002233, 2'h1},
        '{11'h010, 13'h0000, 32'h000000DB, 32'h0, 2'h3},
        '{11'h032, 13'h0020, 32'h0, 32'h000000AA, 2'h3},
        '{11'h030, 13'h0000, 32'h00000018, 32'h0, 2'h0},
        '{11'h000, 13'h0231, 32'h00000077, 32'h0, 2'h0},
        '{11'h10C, 13'h0001, 32'h0000005C, 32'h0, 2'h0},
        '{11'h40E, 13'h0001, 32'h0, 32'h0000185C, 2'h0}
    };
    logic mclk;
    logic resetn;
    logic [4:0] avAddress;
    logic avRead;
    logic avWrite;
    logic [31:0] avWriteData;
    logic [31:0] avReadData;
    logic avWaitrequest;
    logic [9:0] userAddr;
    logic [7:0] userData;
    logic lsbFirst;
    logic sdoActive;
    logic updatePulse;
    logic updSeen;
    logic [31:0] rdWord;
    int n_mismatch;
    int num_checks;
    logic [1:0] rstCnt = 2'h0;
    wire logic devResetn = (rstCnt == 2'h3);

    spid_if link ();
    spid_host i_spid_host (.mclk(mclk), .resetn(resetn),
        .avAddress(avAddress), .avRead(avRead), .avWrite(avWrite),
        .avWriteData(avWriteData), .avReadData(avReadData),
        .avWaitrequest(avWaitrequest), .link(link));
    spid_device i_spid_device (.link(link), .resetn(devResetn),
        .userAddr(userAddr), .userData(userData), .lsbFirst(lsbFirst),
        .sdoActive(sdoActive), .updatePulse(updatePulse));
    spid_props i_spid_props (.sclk(link.sclk), .resetn(devResetn),
        .csN(link.csN), .hostSdioOe(link.hostSdioOe),
        .devSdioOe(link.devSdioOe), .devSdoOe(link.devSdoOe));

    always #25 mclk = ~mclk;
    // device reset lives on sclk: held for three rises after host reset
    always @(posedge link.sclk or negedge resetn)
        if (!resetn)
            rstCnt <= 2'h0;
        else if (rstCnt != 2'h3)
            rstCnt <= 2'(rstCnt + 2'h1);
    // pulse lives one sclk only, so keep it sticky
    always @(posedge link.sclk)
        if (updatePulse === 1'b1)
            updSeen <= 1'b1;

    task automatic print_verdict;
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : print_verdict

    task automatic fail(input string msg);
        n_mismatch++;
        $display("[FAIL] %0t %s", $time, msg);
    endtask : fail

    task automatic chkVal(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp)
            fail($sformatf("word %h expected %h", got, exp));
    endtask : chkVal

    task automatic chkFlag(input logic got, input logic exp);
        num_checks++;
        if (got !== exp)
            fail($sformatf("flag %b expected %b", got, exp));
    endtask : chkFlag

    task automatic avAccess(input logic rd, input logic [4:0] a,
            input logic [31:0] d);
        int i;
        @(posedge mclk);
        avAddress <= a;
        avRead <= rd;
        avWrite <= ~rd;
        avWriteData <= d;
        for (i = 0; i < 64; i++)
        begin
            @(posedge mclk);
            if (avWaitrequest === 1'b0)
                break;
        end
        rdWord = avReadData;
        avRead <= 1'b0;
        avWrite <= 1'b0;
        if (i == 64)
        begin
            fail("bus hang");
            print_verdict();
        end
    endtask : avAccess

    task automatic xfer(input logic [10:0] c, input logic [12:0] a,
            input logic [31:0] tx);
        int i;
        avAccess(1'b0, spid_pkg::REG_ADDR, {19'h00000, a});
        avAccess(1'b0, spid_pkg::REG_TX, tx);
        avAccess(1'b0, spid_pkg::REG_CTRL, {21'h00000, c} | 32'h1);
        for (i = 0; i < 2000; i++)
        begin
            avAccess(1'b1, spid_pkg::REG_STAT, 32'h0);
            if (rdWord[spid_pkg::STAT_DONE] === 1'b1)
                break;
        end
        if (i == 2000)
        begin
            fail("transfer hang");
            print_verdict();
        end
        avAccess(1'b1, spid_pkg::REG_RX, 32'h0);
    endtask : xfer

    // bytes that a read really returns; upper ones are not promised
    function automatic logic [31:0] rxMask(input logic [10:0] c);
        int n;
        n = int'(c[3:2]) + 1;
        if (c[3:2] == 2'h3)
            n = (c[10:8] == 3'h0) ? 1 : int'(c[10:8]);
        return (n >= 4) ? 32'hFFFFFFFF : ((32'h1 << (8 * n)) - 32'h1);
    endfunction : rxMask

    initial
    begin
        mclk = 1'b0;
        resetn = 1'b0;
        avAddress = 5'h00;
        avRead = 1'b0;
        avWrite = 1'b0;
        avWriteData = 32'h0;
        userAddr = 10'h000;
        updSeen = 1'b0;
        n_mismatch = 0;
        num_checks = 0;
        repeat (2) @(posedge mclk);
        resetn <= 1'b1;
        repeat (40) @(posedge mclk);
        foreach (ROWS[r])
        begin
            xfer(ROWS[r].ctrl, ROWS[r].addr, ROWS[r].tx);
            if (ROWS[r].ctrl[1])
                chkVal(rdWord & rxMask(ROWS[r].ctrl), ROWS[r].rx);
            chkVal(32'({sdoActive, lsbFirst}), 32'(ROWS[r].mode));
            $display("row %0d done", r);
        end
        $display("transfer table done");
        userAddr <= 10'h012;
        repeat (8) @(posedge mclk);
        chkVal({24'h0, userData}, 32'h0);
        xfer(11'h000, 13'h0232, 32'h00000001);
        repeat (8) @(posedge mclk);
        chkFlag(updSeen, 1'b1);
        chkVal({24'h0, userData}, 32'h00000011);
        $display("update test done");
        avAccess(1'b1, 5'h14, 32'h0);
        chkVal(rdWord, 32'h0);
        $display("unmapped read done");
        xfer(11'h000, 13'h0000, 32'h0000005A);
        chkFlag(lsbFirst, 1'b1);
        resetn <= 1'b0;
        repeat (4) @(posedge mclk);
        resetn <= 1'b1;
        repeat (40) @(posedge mclk);
        chkFlag(lsbFirst, 1'b0);
        chkVal({24'h0, userData}, 32'h0);
        xfer(11'h002, 13'h0000, 32'h0);
        chkVal(rdWord & 32'hFF, 32'h00000018);
        $display("reset test done");
        print_verdict();
    end
endmodule : serial_port_instruction_decoder_tb_top
`default_nettype wire
